// ==== design/fhpc_pkg.sv ====
// package: constants and carrier types for the flash host pin controller
package fhpc_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  // timing figures in ns, counts derived at 100 ns clock period
  localparam int CLK_PERIOD_NS          = 100;
  localparam int RESET_PULSE_MIN_NS     = 500;
  localparam int RESET_RECOVERY_TIME_NS = 50000;
  localparam int ACCESS_NS              = 300;
  localparam int RESET_PULSE_CYC        =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC           =
    (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC             = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_TIMEOUT_CYC       = 65535;
  localparam int CNT_W                  = 16;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fhpc_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
  } fhpc_ctl_t;

  typedef enum logic [5:0] {
    ST_RESET   = 6'h01,
    ST_RECOVER = 6'h02,
    ST_IDLE    = 6'h04,
    ST_SETUP   = 6'h08,
    ST_STROBE  = 6'h10,
    ST_HOLD    = 6'h20
  } fhpc_state_t;
endpackage

// ==== design/fhpc_timer.sv ====
// cycle down-counter with a one-cycle done pulse
`timescale 1ns/1ps
module fhpc_timer
  import fhpc_pkg::*;
(
  input  wire logic             clk_in,   // clock
  input  wire logic             arst_n_in, // async reset, low
  input  wire logic             load_in,  // load count
  input  wire logic [CNT_W-1:0] count_in, // cycles to run
  output logic                  done_out  // pulse when count expires
);
  logic [CNT_W-1:0] cnt;
  logic             run;
  wire              last = run && (cnt == 16'h0001);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt      <= 16'h0000;
      run      <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= last && !load_in;
      if (load_in) begin
        cnt <= count_in;
        run <= 1'b1;
      end else if (run) begin
        cnt <= cnt - 16'h0001;
        run <= !last;
      end
    end
  end
endmodule

// ==== design/fhpc_host.sv ====
// host-side pin controller for an asynchronous parallel nor flash
`timescale 1ns/1ps
// Function
// (R1) address and data on separate lines together
// (R2) sixteen data lines carry both directions
// (R3) chip select low selects the flash
// (R4) flash drives data only while oe low
// (R5) write strobe low means host to flash
// (R6) protect low locks the boundary sector
// (R7) protect pin pulled up inside flash
// (R8) open-drain ready_busy_n reports algorithm progress
// (R9) ready_busy_n low while erasing, programming, resetting
// (R10) ready_busy_n released when ready or standby
// (R11) trust ready_busy_n only after last strobe
// (R12) failed algorithm keeps ready_busy_n low
// (R13) valid reset aborts and tristates flash outputs
// (R14) reset clears status, controller to standby
// (R15) chip select ignored during reset recovery
// (R16) reissue interrupted operation after reset; the host keeps no copy and reissues nothing, that is left to the user
// (R17) never drive oe and we low together
module fhpc_host
  import fhpc_pkg::*;
(
  input  wire logic              REF_CLK_IN,        // 10 MHz clock
  input  wire logic              ARST_N_IN,         // async reset, low
  input  wire logic              REQ_VALID_IN,      // user request valid
  input  wire logic              REQ_WRITE_IN,      // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] REQ_ADDR_IN,       // word address
  input  wire logic [DATA_W-1:0] REQ_WDATA_IN,      // write data
  input  wire logic              HW_RESET_IN,       // pulse: issue hardware reset
  input  wire logic              LOCK_BOUNDARY_IN,  // 1 protects boundary sector
  input  wire logic [DATA_W-1:0] DATA_LINES_IN,     // flash data lines seen
  input  wire logic              READY_BUSY_N_IN,   // flash ready/busy, pulled up
  output logic                   REQ_READY_OUT,     // may take a request
  output logic                   RSP_VALID_OUT,     // read data pulse
  output logic [DATA_W-1:0]      RSP_RDATA_OUT,     // read data
  output logic                   BUSY_OUT,          // flash algorithm busy
  output logic                   FAIL_OUT,          // busy timed out, likely failure
  output logic [ADDR_W-1:0]      ADDR_OUT,          // flash address lines
  output logic [DATA_W-1:0]      DATA_LINES_OUT,    // flash data lines driven
  output logic                   DATA_LINES_OE_N_OUT, // low while host drives data
  output logic                   CE_N_OUT,          // flash chip select
  output logic                   OE_N_OUT,          // flash output drive enable
  output logic                   WE_N_OUT,          // flash write strobe
  output logic                   RESET_N_OUT,       // flash hardware reset
  output logic                   WP_N_OUT           // flash sector lock
);
  fhpc_state_t      state;
  fhpc_state_t      next_state;
  fhpc_req_t        req;
  fhpc_ctl_t        next_ctl;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic             tmr_done;
  logic             valid_window;
  logic [CNT_W-1:0] busy_cnt;

  fhpc_timer u_timer (
    .clk_in    (REF_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .load_in   (tmr_load),
    .count_in  (tmr_count),
    .done_out  (tmr_done)
  );

  // a flash reset wins over a pending request, so nothing starts mid-reset
  wire take_req  = (state == ST_IDLE) && REQ_READY_OUT && REQ_VALID_IN &&
                   !HW_RESET_IN;                                   // [R16]
  wire go_reset  = (state == ST_IDLE) && HW_RESET_IN;
  wire is_write  = req.write;
  // read result is sampled at end of strobe with oe low
  wire read_done = (state == ST_STROBE) && tmr_done && !is_write;
  // the busy pin is ignored until a write strobe or a reset has finished
  wire busy_seen = valid_window && !READY_BUSY_N_IN;               // [R11]

  // a phase lasts its count plus one cycle, so every figure errs long
  // one timer serves every timed phase; load on entry to reset, recover and strobe
  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_count  = 16'h0001;
    case (state)
      ST_RESET: begin
        if (tmr_done) begin
          next_state = ST_RECOVER;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(RECOVERY_CYC);
        end
      end
      ST_RECOVER: begin
        if (tmr_done) next_state = ST_IDLE;                        // [R15]
      end
      ST_IDLE: begin
        if (go_reset) begin
          next_state = ST_RESET;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(RESET_PULSE_CYC);                    // [R13]
        end else if (take_req) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_state = ST_STROBE;
        tmr_load   = 1'b1;
        tmr_count  = CNT_W'(ACCESS_CYC);
      end
      ST_STROBE: begin
        if (tmr_done) next_state = ST_HOLD;
      end
      ST_HOLD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // pin levels per state; oe and we are never low together
  always_comb begin
    next_ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1};
    case (next_state)
      ST_RESET:   next_ctl.reset_n = 1'b0;                         // [R13] [R14]
      ST_SETUP:   next_ctl.ce_n    = 1'b0;                         // [R3]
      ST_STROBE: begin
        next_ctl.ce_n = 1'b0;
        next_ctl.we_n = !is_write;                                 // [R5] [R17]
        next_ctl.oe_n = is_write;                                  // [R4] [R17]
      end
      ST_HOLD:    next_ctl.ce_n    = 1'b0;
      default:    next_ctl.ce_n    = 1'b1;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state <= ST_IDLE;
      req   <= '0;
    end else begin
      state <= next_state;
      if (take_req) req <= '{write: REQ_WRITE_IN, addr: REQ_ADDR_IN, wdata: REQ_WDATA_IN};
    end
  end

  // address and data presented together on separate lines
  wire [ADDR_W-1:0] next_addr    = take_req ? REQ_ADDR_IN : req.addr;   // [R1]
  wire [DATA_W-1:0] next_wdata   = take_req ? REQ_WDATA_IN : req.wdata; // [R1] [R2]
  // drive only through write cycles, never while flash may drive
  wire              next_dq_oe_n = !(is_write && (next_state == ST_STROBE ||
                                     next_state == ST_HOLD));          // [R2]

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CE_N_OUT            <= 1'b1;
      OE_N_OUT            <= 1'b1;
      WE_N_OUT            <= 1'b1;
      RESET_N_OUT         <= 1'b1;
      ADDR_OUT            <= '0;
      DATA_LINES_OUT      <= 16'h0000;
      DATA_LINES_OE_N_OUT <= 1'b1;
      WP_N_OUT            <= 1'b1;
    end else begin
      CE_N_OUT            <= next_ctl.ce_n;
      OE_N_OUT            <= next_ctl.oe_n;
      WE_N_OUT            <= next_ctl.we_n;
      RESET_N_OUT         <= next_ctl.reset_n;
      ADDR_OUT            <= next_addr;
      DATA_LINES_OUT      <= next_wdata;
      DATA_LINES_OE_N_OUT <= next_dq_oe_n;
      WP_N_OUT            <= !LOCK_BOUNDARY_IN;                    // [R6]
    end
  end

  // busy tracking; long busy is reported as a probable failure
  wire window_open  = (state == ST_HOLD && is_write) ||
                      (state == ST_RESET && tmr_done);             // [R11]
  wire window_close = (state == ST_RESET);
  wire busy_full    = (busy_cnt == CNT_W'(BUSY_TIMEOUT_CYC));
  wire next_ready   = (next_state == ST_IDLE) && !take_req;

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      valid_window <= 1'b0;
      BUSY_OUT     <= 1'b0;
    end else begin
      if (window_open)
        valid_window <= 1'b1;                                      // [R11]
      else if (window_close)
        valid_window <= 1'b0;
      BUSY_OUT <= busy_seen;                                       // [R8] [R9] [R10]
    end
  end

  // saturates so a stuck pin cannot wrap back to zero
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      busy_cnt <= 16'h0000;
    end else if (!busy_seen) begin
      busy_cnt <= 16'h0000;
    end else if (!busy_full) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end

  // stuck busy clears only by a flash reset; a timeout landing on the
  // reset pulse is cleared a cycle later, once the count has dropped
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      FAIL_OUT <= 1'b0;
    end else if (busy_full) begin
      FAIL_OUT <= 1'b1;                                            // [R12]
    end else if (state == ST_RESET) begin
      FAIL_OUT <= 1'b0;                                            // [R12] [R14]
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      REQ_READY_OUT <= 1'b0;
      RSP_VALID_OUT <= 1'b0;
      RSP_RDATA_OUT <= 16'h0000;
    end else begin
      REQ_READY_OUT <= next_ready;
      RSP_VALID_OUT <= read_done;
      if (read_done) RSP_RDATA_OUT <= DATA_LINES_IN;               // [R2] [R4]
    end
  end
endmodule

// ==== verification/fhpc_flash_model.sv ====
// behavioural flash device seen from its pins
`timescale 1ns/1ps
module fhpc_flash_model
  import fhpc_pkg::*;
(
  input  wire logic              clk_in,      // time base
  input  wire logic              ce_n_in,     // chip select
  input  wire logic              oe_n_in,     // output enable
  input  wire logic              we_n_in,     // write strobe
  input  wire logic              reset_n_in,  // hardware reset
  input  wire logic              wp_n_in,     // sector lock
  input  wire logic [ADDR_W-1:0] addr_in,     // address
  input  wire logic [DATA_W-1:0] dq_in,       // resolved data
  output logic [DATA_W-1:0]      dq_out,      // data driven
  output logic                   dq_drv_out,  // high while driving
  output logic                   rb_pull_out  // high pulls busy low
);
  logic [DATA_W-1:0] mem [16];
  int                busy;
  logic              failed = 1'b0;
  // unconnected lock pin floats up to unprotected
  wire               wp_high = (wp_n_in !== 1'b0);
  initial for (int i = 0; i < 16; i++) mem[i] = 16'ha5a0 + 16'(i);
  assign dq_drv_out  = !ce_n_in && !oe_n_in && we_n_in && reset_n_in;
  assign dq_out      = mem[addr_in[3:0]];
  assign rb_pull_out = busy != 0 || failed || !reset_n_in;
  // lowest 64-kword sector is the locked one
  always @(posedge we_n_in) if (!ce_n_in && reset_n_in) begin
    if (!wp_high && addr_in[ADDR_W-1:16] == '0) failed <= 1'b1;
    else begin
      mem[addr_in[3:0]] <= dq_in;
      busy <= 20;
    end
  end
  // non-blocking so the host samples the pin before this edge's update
  always @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in) begin
      busy <= 0;
      failed <= 1'b0;
    end else if (busy != 0) busy <= busy - 1;
endmodule

// ==== verification/fhpc_host_asserts.sv ====
// pin timing checks on the host controller ports
`timescale 1ns/1ps
module fhpc_host_asserts (
  input wire logic REF_CLK_IN,  // clock
  input wire logic ARST_N_IN,   // reset
  input wire logic REQ_VALID_IN, // valid
  input wire logic REQ_WRITE_IN, // write
  input wire logic HW_RESET_IN, // reset request
  input wire logic LOCK_BOUNDARY_IN, // lock
  input wire logic READY_BUSY_N_IN, // busy pin
  input wire logic REQ_READY_OUT, // ready
  input wire logic RSP_VALID_OUT, // response
  input wire logic BUSY_OUT,    // busy
  input wire logic FAIL_OUT,    // fail
  input wire logic DATA_LINES_OE_N_OUT, // host drive
  input wire logic CE_N_OUT,    // select
  input wire logic OE_N_OUT,    // output enable
  input wire logic WE_N_OUT,    // strobe
  input wire logic RESET_N_OUT, // flash reset
  input wire logic WP_N_OUT     // lock pin
);
  int unsigned rec;
  wire take = REQ_VALID_IN && REQ_READY_OUT && !HW_RESET_IN;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // counts the recovery span after the reset pulse
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN) rec <= 0;
    else if (!RESET_N_OUT) rec <= 500;
    else if (rec != 0) rec <= rec - 1;
  property p_clash; !(!OE_N_OUT && !WE_N_OUT); endproperty
  a_clash: assert property (p_clash) else $error("oe and we low together");
  property p_sel; (!OE_N_OUT || !WE_N_OUT) |-> !CE_N_OUT; endproperty
  a_sel: assert property (p_sel) else $error("strobe without select");
  property p_drv; !DATA_LINES_OE_N_OUT |-> OE_N_OUT; endproperty
  a_drv: assert property (p_drv) else $error("host drives with oe low");
  property p_wdir; !WE_N_OUT |-> !DATA_LINES_OE_N_OUT; endproperty
  a_wdir: assert property (p_wdir) else $error("write strobe without data");
  property p_lock; 1'b1 |=> WP_N_OUT == !$past(LOCK_BOUNDARY_IN); endproperty
  a_lock: assert property (p_lock) else $error("lock pin wrong");
  property p_rd; take && !REQ_WRITE_IN |-> ##[6:7] RSP_VALID_OUT; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_pulse; $fell(RESET_N_OUT) |-> !RESET_N_OUT [*6] ##1 RESET_N_OUT; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  property p_rec; (rec != 0 || !RESET_N_OUT) |-> CE_N_OUT; endproperty
  a_rec: assert property (p_rec) else $error("select during recovery");
  property p_busy; BUSY_OUT |-> !$past(READY_BUSY_N_IN) || !$past(READY_BUSY_N_IN, 2)
    || !$past(READY_BUSY_N_IN, 3); endproperty
  a_busy: assert property (p_busy) else $error("busy without pin low");
  c_read: cover property (take && !REQ_WRITE_IN);
  c_reset: cover property ($fell(RESET_N_OUT));
  c_fail: cover property ($rose(FAIL_OUT));
endmodule
bind fhpc_host fhpc_host_asserts u_chk (
  .REF_CLK_IN          (REF_CLK_IN),
  .ARST_N_IN           (ARST_N_IN),
  .REQ_VALID_IN        (REQ_VALID_IN),
  .REQ_WRITE_IN        (REQ_WRITE_IN),
  .HW_RESET_IN         (HW_RESET_IN),
  .LOCK_BOUNDARY_IN    (LOCK_BOUNDARY_IN),
  .READY_BUSY_N_IN     (READY_BUSY_N_IN),
  .REQ_READY_OUT       (REQ_READY_OUT),
  .RSP_VALID_OUT       (RSP_VALID_OUT),
  .BUSY_OUT            (BUSY_OUT),
  .FAIL_OUT            (FAIL_OUT),
  .DATA_LINES_OE_N_OUT (DATA_LINES_OE_N_OUT),
  .CE_N_OUT            (CE_N_OUT),
  .OE_N_OUT            (OE_N_OUT),
  .WE_N_OUT            (WE_N_OUT),
  .RESET_N_OUT         (RESET_N_OUT),
  .WP_N_OUT            (WP_N_OUT)
);

// ==== verification/tb.sv ====
// testbench: host controller against a behavioural flash
`timescale 1ns/1ps
module tb;
  import fhpc_pkg::*;
  logic              clk, arst_n, req_valid, req_write, hw_reset, lock, req_ready, rsp_valid;
  logic              busy, fail, dq_oe_n, ce_n, oe_n, we_n, rst_n, wp_n, m_drv, m_pull;
  logic [ADDR_W-1:0] req_addr, addr;
  logic [DATA_W-1:0] req_wdata, dq, m_dq, h_dq, rdata;
  logic [DATA_W-1:0] dq_last = '0;
  int                err_total, n_tests;
  // undriven bus shows a changing pattern, never the last value
  assign dq = !dq_oe_n ? h_dq : m_drv ? m_dq : ~dq_last;
  always @(posedge clk) dq_last <= dq;
  fhpc_host DUT (.REF_CLK_IN(clk), .ARST_N_IN(arst_n), .REQ_VALID_IN(req_valid),
    .REQ_WRITE_IN(req_write), .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata),
    .HW_RESET_IN(hw_reset), .LOCK_BOUNDARY_IN(lock), .DATA_LINES_IN(dq),
    .READY_BUSY_N_IN(!m_pull), .REQ_READY_OUT(req_ready), .RSP_VALID_OUT(rsp_valid),
    .RSP_RDATA_OUT(rdata), .BUSY_OUT(busy), .FAIL_OUT(fail), .ADDR_OUT(addr),
    .DATA_LINES_OUT(h_dq), .DATA_LINES_OE_N_OUT(dq_oe_n), .CE_N_OUT(ce_n), .OE_N_OUT(oe_n),
    .WE_N_OUT(we_n), .RESET_N_OUT(rst_n), .WP_N_OUT(wp_n));
  fhpc_flash_model u_flash (.clk_in(clk), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .reset_n_in(rst_n), .wp_n_in(wp_n), .addr_in(addr), .dq_in(dq), .dq_out(m_dq),
    .dq_drv_out(m_drv), .rb_pull_out(m_pull));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_for(input int sel, input logic val, input int lim);
    logic cur;
    cur = 1'bx;
    for (int i = 0; i <= lim; i++) begin
      cur = sel == 0 ? busy : sel == 1 ? fail : req_ready;
      if (cur === val) begin
        n_tests++;
        return;
      end
      @(posedge clk) #1;
    end
    err_total++;
    $display("Error at %0t: got %h expected %h", $time, cur, val);
    report_and_stop;
  endtask
  task automatic req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wait_for(2, 1'b1, 1000);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(posedge clk) #1;
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    req(1'b0, a, '0);
    for (int i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(posedge clk) #1;
    chk(rsp_valid, 1'b1);
    if (rsp_valid !== 1'b1) report_and_stop;
    chk(rdata, exp);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic bad);
    req(1'b1, a, d);
    wait_for(0, 1'b1, 30);
    if (bad) wait_for(1, 1'b1, 70000);
    else wait_for(0, 1'b0, 100);
  endtask
  task automatic sc_rw;
    wr(26'h0400003, 16'hbeef, 1'b0);
    rd(26'h0400003, 16'hbeef);
    rd(26'h0400007, 16'ha5a7);
  endtask
  task automatic sc_lock_fail;
    lock = 1'b1;
    @(posedge clk) #1;
    @(posedge clk) #1;
    chk(wp_n, 1'b0);
    wr(26'h0000005, 16'h1111, 1'b1);
    chk(busy, 1'b1);
  endtask
  task automatic sc_reset;
    hw_reset = 1'b1;
    @(posedge clk) #1;
    hw_reset = 1'b0;
    wait_for(2, 1'b1, 1000);
    chk(fail, 1'b0);
    chk(busy, 1'b0);
    rd(26'h0000005, 16'ha5a5);
    lock = 1'b0;
    wr(26'h0000005, 16'h1234, 1'b0);
    rd(26'h0000005, 16'h1234);
    chk(wp_n, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {arst_n, req_valid, req_write, hw_reset, lock, req_addr, req_wdata} = '0;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    sc_rw();
    sc_lock_fail();
    sc_reset();
    report_and_stop();
  end
endmodule
